// ==== core/fps_pkg.sv ====
// Package for the flat panel power sequencer: register map, fields, timing constants
package fps_pkg;
	// Timing base
	localparam int CLK_HZ = 25000000;
	localparam int TICK_MS = 1;
	localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
	// Delay ranges in ms
	localparam int RISE_MAX_MS = 10;
	localparam int LINK_MAX_MS = 50;
	localparam int BKLT_MIN_MS = 200;
	localparam int OFF_MAX_MS = 50;
	localparam int CYCLE_MAX_MS = 400;
	// Register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_UP = 4'h4;
	localparam logic [3:0] OFS_DOWN = 4'h8;
	localparam logic [3:0] OFS_STAT = 4'hc;
	// Control fields
	localparam int CTRL_POWER_ON = 0;
	localparam int CTRL_OVERRIDE = 1;
	localparam int CTRL_EDP_CTRL = 2;
	localparam int CTRL_LINK_SEL = 4;
	// Reset values of the delay fields, in ms
	localparam logic [7:0] RST_RISE = 8'h0a;
	localparam logic [7:0] RST_LINK = 8'h32;
	localparam logic [15:0] RST_BKLT = 16'h00c8;
	localparam logic [7:0] RST_BOFF = 8'h0a;
	localparam logic [7:0] RST_OFF = 8'h32;
	localparam logic [15:0] RST_CYCLE = 16'h0190;

	typedef enum {FPS_OFF, FPS_CYCLE, FPS_RISE, FPS_LINK, FPS_BKLT, FPS_ON,
		FPS_BOFF, FPS_LOFF} fps_state_t;

	typedef struct packed {
		logic [7:0] rise_ms;
		logic [7:0] link_ms;
		logic [15:0] bklt_ms;
	} fps_up_t;

	typedef struct packed {
		logic [7:0] boff_ms;
		logic [7:0] off_ms;
		logic [15:0] cycle_ms;
	} fps_down_t;

	typedef struct packed {
		logic panel_supply_enable;
		logic link_active;
		logic backlight_enable_out;
		logic edp_backlight_enable_out;
		logic edp_backlight_control_out;
	} fps_out_t;
endpackage

// ==== core/fps_sequencer.sv ====
// Flat panel power sequencer with Avalon-MM register slave
// What this block does
// (RL1) The sequencer alone owns panel supply, backlight and LVDS line activity.
// (RL2) Separate panel supply and backlight enable outputs are switched by the sequencer.
// (RL3) Power-up waits until the programmed power cycle delay (0 to 400 ms) since last power-off.
// (RL4) LVDS lines go active the programmed 0 to 50 ms after the supply is stable.
// (RL5) Backlight enable follows LVDS active by the programmed delay, never under 200 ms.
// (RL6) Power-down turns the backlight off first, then waits the programmed delay before LVDS off.
// (RL7) Supply removal begins the programmed 0 to 50 ms after LVDS off.
// (RL8) Software programs every sequencing delay.
// (RL9) Software should follow the ordered sequence with delays inside the panel range.
// (RL10) Embedded port outputs: supply, backlight enable and backlight control.
// (RL11) When configured, the sequencer overrides the LVDS pair power state during sequencing.
// (RL12) After supply enable the sequencer waits the rise allowance (at most 10 ms).
`timescale 1ns/10ps
module fps_sequencer #(
	parameter int CYC_PER_MS = fps_pkg::CYC_PER_MS
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [3:0] lvds_pair_pd_sw_i,
	output logic [3:0] lvds_pair_pd_o,
	output logic panel_supply_enable_o,
	output logic link_active_o,
	output logic backlight_enable_out_o,
	output logic edp_backlight_enable_out_o,
	output logic edp_backlight_control_out_o
);
	logic [31:0] ctrl, next_ctrl;
	fps_pkg::fps_up_t up, next_up;
	fps_pkg::fps_down_t down, next_down;
	logic [31:0] rdata, next_rdata;
	logic ack, next_ack;
	fps_pkg::fps_state_t state, next_state;
	logic [15:0] ms_cnt, next_ms_cnt;
	logic [24:0] pre, next_pre;
	fps_pkg::fps_out_t outs, next_outs;
	logic tick;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Clamp keeps the backlight wait at or above its floor whatever software writes
	function automatic logic [15:0] clamp_lo(input logic [15:0] v, input int lo);
		return (v < 16'(lo)) ? 16'(lo) : v;
	endfunction

	function automatic logic [15:0] clamp_hi(input logic [15:0] v, input int hi);
		return (v > 16'(hi)) ? 16'(hi) : v;
	endfunction

	// One-cycle wait state; every access is answered on the second edge
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
	assign avs_readdata_o = rdata;

	always_comb begin
		next_ctrl = ctrl;
		next_up = up;
		next_down = down;
		next_rdata = rdata;
		next_ack = 1'b0;
		if ((avs_read_i | avs_write_i) && !ack) begin
			next_ack = 1'b1;
			if (avs_write_i) begin
				if (avs_address_i == fps_pkg::OFS_CTRL) begin
					next_ctrl = merge(ctrl, avs_writedata_i, avs_byteenable_i) & 32'h00000017;
				end else if (avs_address_i == fps_pkg::OFS_UP) begin
					next_up = merge(up, avs_writedata_i, avs_byteenable_i); // [RL8]
				end else if (avs_address_i == fps_pkg::OFS_DOWN) begin
					next_down = merge(down, avs_writedata_i, avs_byteenable_i); // [RL8]
				end
			end else begin
				if (avs_address_i == fps_pkg::OFS_CTRL) begin
					next_rdata = ctrl;
				end else if (avs_address_i == fps_pkg::OFS_UP) begin
					next_rdata = up;
				end else if (avs_address_i == fps_pkg::OFS_DOWN) begin
					next_rdata = down;
				end else if (avs_address_i == fps_pkg::OFS_STAT) begin
					next_rdata = {24'h000000, 3'(state), outs};
				end else begin
					next_rdata = 32'h00000000;
				end
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl <= 32'h00000000;
			up <= {fps_pkg::RST_RISE, fps_pkg::RST_LINK, fps_pkg::RST_BKLT};
			down <= {fps_pkg::RST_BOFF, fps_pkg::RST_OFF, fps_pkg::RST_CYCLE};
			rdata <= 32'h00000000;
			ack <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			up <= next_up;
			down <= next_down;
			rdata <= next_rdata;
			ack <= next_ack;
		end
	end

	// Millisecond time base
	assign tick = (pre == 25'(CYC_PER_MS - 1));

	always_comb begin
		logic on_req;
		on_req = ctrl[fps_pkg::CTRL_POWER_ON];
		next_pre = tick ? 25'h0000000 : pre + 25'h0000001;
		next_state = state;
		next_ms_cnt = (tick && ms_cnt != 16'h0000) ? ms_cnt - 16'h0001 : ms_cnt;
		next_outs = outs;
		case (state)
			fps_pkg::FPS_OFF: begin
				if (on_req) begin
					next_state = fps_pkg::FPS_CYCLE;
				end
			end
			fps_pkg::FPS_CYCLE: begin
				if (!on_req) begin
					next_state = fps_pkg::FPS_OFF;
				end else if (ms_cnt == 16'h0000) begin // [RL3]
					next_state = fps_pkg::FPS_RISE;
					next_outs.panel_supply_enable = 1'b1; // [RL2]
					next_ms_cnt = clamp_hi({8'h00, up.rise_ms}, fps_pkg::RISE_MAX_MS); // [RL12]
					next_pre = 25'h0000000;
				end
			end
			fps_pkg::FPS_RISE: begin
				if (ms_cnt == 16'h0000) begin // [RL12]
					next_state = fps_pkg::FPS_LINK;
					next_ms_cnt = clamp_hi({8'h00, up.link_ms}, fps_pkg::LINK_MAX_MS);
					next_pre = 25'h0000000;
				end
			end
			fps_pkg::FPS_LINK: begin
				if (ms_cnt == 16'h0000) begin
					next_state = fps_pkg::FPS_BKLT;
					next_outs.link_active = 1'b1; // [RL4]
					next_ms_cnt = clamp_lo(up.bklt_ms, fps_pkg::BKLT_MIN_MS);
					next_pre = 25'h0000000;
				end
			end
			fps_pkg::FPS_BKLT: begin
				if (!on_req) begin
					next_state = fps_pkg::FPS_BOFF;
					next_ms_cnt = {8'h00, down.boff_ms};
					next_pre = 25'h0000000;
				end else if (ms_cnt == 16'h0000) begin // [RL5]
					next_state = fps_pkg::FPS_ON;
					next_outs.backlight_enable_out = 1'b1; // [RL2]
					next_outs.edp_backlight_enable_out = 1'b1; // [RL10]
				end
			end
			fps_pkg::FPS_ON: begin
				if (!on_req) begin
					next_state = fps_pkg::FPS_BOFF;
					next_outs.backlight_enable_out = 1'b0; // [RL6]
					next_outs.edp_backlight_enable_out = 1'b0;
					next_ms_cnt = {8'h00, down.boff_ms};
					next_pre = 25'h0000000;
				end
			end
			fps_pkg::FPS_BOFF: begin
				if (ms_cnt == 16'h0000) begin // [RL6]
					next_state = fps_pkg::FPS_LOFF;
					next_outs.link_active = 1'b0;
					next_ms_cnt = clamp_hi({8'h00, down.off_ms}, fps_pkg::OFF_MAX_MS);
					next_pre = 25'h0000000;
				end
			end
			fps_pkg::FPS_LOFF: begin
				if (ms_cnt == 16'h0000) begin // [RL7]
					next_state = fps_pkg::FPS_CYCLE;
					next_outs.panel_supply_enable = 1'b0;
					next_ms_cnt = clamp_hi(down.cycle_ms, fps_pkg::CYCLE_MAX_MS); // [RL3]
					next_pre = 25'h0000000;
				end
			end
			default: begin
				next_state = fps_pkg::FPS_OFF;
			end
		endcase
		// Backlight control level mirrors its software bit only while lit
		next_outs.edp_backlight_control_out = next_outs.edp_backlight_enable_out
			& ctrl[fps_pkg::CTRL_EDP_CTRL]; // [RL10]
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= fps_pkg::FPS_OFF;
			ms_cnt <= 16'h0000;
			pre <= 25'h0000000;
			outs <= '0;
		end else begin
			state <= next_state;
			ms_cnt <= next_ms_cnt;
			pre <= next_pre;
			outs <= next_outs;
		end
	end

	// Sequencer owns every panel control [RL1]
	assign panel_supply_enable_o = outs.panel_supply_enable;
	assign link_active_o = outs.link_active;
	assign backlight_enable_out_o = outs.backlight_enable_out;
	assign edp_backlight_enable_out_o = outs.edp_backlight_enable_out;
	assign edp_backlight_control_out_o = outs.edp_backlight_control_out;

	// Under override the pairs track the link in every state but FPS_ON, forced down while it is inactive [RL11]
	assign lvds_pair_pd_o = (ctrl[fps_pkg::CTRL_OVERRIDE] && state != fps_pkg::FPS_ON)
		? {4{~outs.link_active}} : lvds_pair_pd_sw_i;

	chk_bklt_after_link: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL5]
		$rose(backlight_enable_out_o) |-> link_active_o && panel_supply_enable_o)
		else $error("backlight rose without link and supply");
	chk_bklt_first_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL6]
		$fell(link_active_o) |-> !backlight_enable_out_o)
		else $error("link dropped while backlight on");
	chk_supply_last: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL7]
		$fell(panel_supply_enable_o) |-> !link_active_o && !backlight_enable_out_o)
		else $error("supply dropped with link or backlight on");
	chk_link_needs_supply: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL4]
		$rose(link_active_o) |-> $past(panel_supply_enable_o))
		else $error("link active before supply");
	chk_supply_from_cycle: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL3]
		$rose(panel_supply_enable_o) |-> $past(state) == fps_pkg::FPS_CYCLE && $past(ms_cnt) == 0)
		else $error("supply rose before cycle delay done");
	chk_rise_wait: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL12]
		$rose(panel_supply_enable_o) |-> state == fps_pkg::FPS_RISE
			&& ms_cnt <= 16'(fps_pkg::RISE_MAX_MS))
		else $error("rise allowance out of range");
	chk_bklt_floor: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL5]
		$rose(link_active_o) |-> ms_cnt >= 16'(fps_pkg::BKLT_MIN_MS))
		else $error("backlight wait below floor");
	chk_edp_mirror: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL10]
		edp_backlight_enable_out_o == backlight_enable_out_o)
		else $error("embedded backlight enable mismatch");
	chk_override: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RL11]
		ctrl[fps_pkg::CTRL_OVERRIDE] && !link_active_o |-> lvds_pair_pd_o == 4'hf)
		else $error("pairs not forced down");
	cov_power_up: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(backlight_enable_out_o));
	cov_power_down: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		$fell(panel_supply_enable_o));
	cov_abort_up: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		state == fps_pkg::FPS_BKLT ##1 state == fps_pkg::FPS_BOFF);
endmodule

// ==== tb/fps_panel_model.sv ====
// Panel supply switch and backlight model: time stamps of every supply, link and backlight enable edge
`timescale 1ns/10ps
module fps_panel_model (
	input wire logic mclk_i,
	input wire fps_pkg::fps_out_t pins_i,
	output int t_sup_on,
	output int t_link_on,
	output int t_bk_on,
	output int t_bk_off,
	output int t_link_off,
	output int t_sup_off,
	output logic order_bad
);
	int now = 0;
	fps_pkg::fps_out_t last = '0;
	// One driver for the flag, so the port is a plain copy
	logic bad = 1'b0;
	assign order_bad = bad;
	always @(posedge mclk_i) begin
		now <= now + 1;
		last <= pins_i;
		if (pins_i.panel_supply_enable && !last.panel_supply_enable) t_sup_on <= now;
		if (!pins_i.panel_supply_enable && last.panel_supply_enable) t_sup_off <= now;
		if (pins_i.link_active && !last.link_active) t_link_on <= now;
		if (!pins_i.link_active && last.link_active) t_link_off <= now;
		if (pins_i.backlight_enable_out && !last.backlight_enable_out) t_bk_on <= now;
		if (!pins_i.backlight_enable_out && last.backlight_enable_out) t_bk_off <= now;
		// A lit panel with no link or no supply would be damaged
		if (pins_i.backlight_enable_out && !(pins_i.link_active && pins_i.panel_supply_enable)) begin
			bad <= 1'b1;
		end
		if (pins_i.link_active && !pins_i.panel_supply_enable) bad <= 1'b1;
		if (pins_i.edp_backlight_enable_out !== pins_i.backlight_enable_out) begin
			bad <= 1'b1;
		end
	end
endmodule

// ==== tb/fps_sequencer_bench.sv ====
// Self-checking bench for the flat panel power sequencer
`timescale 1ns/10ps
module fps_sequencer_bench;
	localparam int CPM = 4;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] be = 4'hf;
	logic [31:0] rdat;
	logic wreq;
	logic [3:0] pd_sw = 4'h0;
	logic [3:0] pd;
	wire fps_pkg::fps_out_t pins;
	int t_sup_on, t_link_on, t_bk_on, t_bk_off, t_link_off, t_sup_off;
	logic order_bad;
	int error_cnt = 0;
	int checked = 0;
	logic [31:0] v;
	always #20 mclk_i = ~mclk_i;
	fps_sequencer #(.CYC_PER_MS(CPM)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
		.lvds_pair_pd_sw_i(pd_sw), .lvds_pair_pd_o(pd),
		.panel_supply_enable_o(pins.panel_supply_enable), .link_active_o(pins.link_active),
		.backlight_enable_out_o(pins.backlight_enable_out),
		.edp_backlight_enable_out_o(pins.edp_backlight_enable_out),
		.edp_backlight_control_out_o(pins.edp_backlight_control_out));
	fps_panel_model i_panel (.mclk_i(mclk_i), .pins_i(pins), .t_sup_on(t_sup_on),
		.t_link_on(t_link_on), .t_bk_on(t_bk_on), .t_bk_off(t_bk_off),
		.t_link_off(t_link_off), .t_sup_off(t_sup_off), .order_bad(order_bad));
	task automatic test_done();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic in_range(input int t, input int lo, input int hi);
		check({31'h0, t >= lo && t <= hi}, 32'h1);
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] b);
		int n;
		n = 0;
		@(posedge mclk_i);
		adr <= a;
		wdat <= d;
		be <= b;
		rd <= !w;
		wr <= w;
		// Waitrequest and read data are both taken at the same rising edge
		do begin
			@(posedge mclk_i);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		v = rdat;
		if (n >= 50) check(32'h0, 32'h1);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hf);
		check(v, e);
	endtask
	// Polls the state field; each poll costs a few cycles only
	task automatic wait_st(input logic [2:0] s);
		int n;
		n = 0;
		do begin
			bus(1'b0, fps_pkg::OFS_STAT, 32'h0, 4'hf);
			n++;
		end while (v[7:5] !== s && n < 1000);
		check({29'h0, v[7:5]}, {29'h0, s});
	endtask
	initial begin
		repeat (40000) @(posedge mclk_i);
		error_cnt++;
		test_done();
	end
	initial begin
		repeat (5) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		check({27'h0, pins}, 32'h0);
		rd_chk(fps_pkg::OFS_CTRL, 32'h0);
		rd_chk(fps_pkg::OFS_UP, 32'h0a3200c8);
		rd_chk(fps_pkg::OFS_DOWN, 32'h0a320190);
		rd_chk(4'h2, 32'h0);
		bus(1'b1, fps_pkg::OFS_UP, 32'h0203ffff, 4'hc);
		rd_chk(fps_pkg::OFS_UP, 32'h020300c8);
		bus(1'b1, fps_pkg::OFS_DOWN, 32'h02030005, 4'hf);
		rd_chk(fps_pkg::OFS_DOWN, 32'h02030005);
		bus(1'b1, fps_pkg::OFS_STAT, 32'hffffffff, 4'hf);
		rd_chk(fps_pkg::OFS_STAT, 32'h0);
		pd_sw <= 4'h5;
		// Unused control bits read back as zero; link select is kept
		bus(1'b1, fps_pkg::OFS_CTRL, 32'hfffffffa, 4'hf);
		rd_chk(fps_pkg::OFS_CTRL, 32'h12);
		check({28'h0, pd}, 32'hf);
		bus(1'b1, fps_pkg::OFS_CTRL, 32'h7, 4'hf);
		wait_st(3'd5);
		check(v, 32'hbf);
		check({27'h0, pins}, 32'h1f);
		check({28'h0, pd}, 32'h5);
		in_range(t_link_on - t_sup_on, 5 * CPM, 7 * CPM + 2);
		in_range(t_bk_on - t_link_on, 200 * CPM, 201 * CPM + 2);
		bus(1'b1, fps_pkg::OFS_CTRL, 32'h2, 4'hf);
		wait_st(3'd0);
		check({27'h0, pins}, 32'h0);
		in_range(t_link_off - t_bk_off, 2 * CPM, 3 * CPM + 2);
		in_range(t_sup_off - t_link_off, 3 * CPM, 4 * CPM + 2);
		// Asked again well inside the off time, so the wait must come from the block
		bus(1'b1, fps_pkg::OFS_CTRL, 32'h1, 4'hf);
		wait_st(3'd4);
		in_range(t_sup_on - t_sup_off, 5 * CPM, 6 * CPM + 8);
		check({31'h0, order_bad}, 32'h0);
		test_done();
	end
endmodule
